// *** hdpm_dsport_link_pm.v ***
// link power manager for one hub downstream facing port
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`include "hdpm_defines.vh"

module hdpm_dsport_link_pm #(
    parameter U1_TICK_CYC = `HDPM_U1_TICK_CYC,
    parameter U2_TICK_CYC = `HDPM_U2_TICK_CYC,
    parameter EXTRA_WAKE_CYC = 16'h0010
) (
    input  wire        REF_CLK_I,
    input  wire        RST_N_I,
    // register port
    input  wire [3:0]  REG_ADDR_I,
    input  wire [7:0]  REG_WDATA_I,
    input  wire        REG_WR_I,
    input  wire        REG_RD_I,
    output reg  [7:0]  REG_RDATA_O,
    // downstream link partner side
    input  wire        PARTNER_U1_REQ_I,
    input  wire        PARTNER_U2_REQ_I,
    input  wire        PARTNER_EXIT_I,
    input  wire        PARTNER_WAKE_I,
    input  wire        PARTNER_ACCEPT_I,
    input  wire        PARTNER_REJECT_I,
    input  wire        TX_PENDING_I,
    input  wire        PKT_ACTIVITY_I,
    input  wire        ROUTED_PKT_I,
    input  wire        ENTER_U3_I,
    output wire        PARTNER_ACCEPT_O,
    output wire        PARTNER_REJECT_O,
    output reg         ENTRY_U1_O,
    output reg         ENTRY_U2_O,
    output reg         EXIT_U0_O,
    output wire        PKT_DROP_O,
    output wire        HDR_ACK_O,
    // hub upstream port side
    input  wire [2:0]  US_STATE_I,
    input  wire        US_WAKE_I,
    input  wire        OTHERS_LE_U1_I,
    input  wire        OTHERS_LE_U2_I,
    input  wire        OTHERS_U2_U3_I,
    output reg         US_GO_U1_O,
    output reg         US_GO_U2_O,
    output reg         US_GO_U0_O,
    output wire [2:0]  PORT_STATE_O
);

    // ------------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------------
    reg  [7:0]  u1_tmo_q;
    reg  [7:0]  u2_tmo_q;
    reg  [1:0]  cfg_q;          // bit0 upstream u1 enable, bit1 upstream u2 enable
    reg  [2:0]  st_q;
    reg  [2:0]  st_d;
    reg         sw_try_q;
    reg         sw_try_d;
    reg         u3_wake_seen_q;
    reg  [7:0]  u1_tmr_q;
    reg  [7:0]  u2_tmr_q;
    reg  [15:0] u1_div_q;
    reg  [15:0] u2_div_q;
    reg  [15:0] wake_dly_q;
    reg         wake_pend_q;
    reg         tmr_clr;
    reg         u2_tmr_clr;

    wire u1_on = (u1_tmo_q != `HDPM_TMO_ZERO);
    wire u2_on = (u2_tmo_q != `HDPM_TMO_ZERO);
    wire wr_u1 = REG_WR_I && (REG_ADDR_I == `HDPM_REG_U1_TMO);
    wire wr_u2 = REG_WR_I && (REG_ADDR_I == `HDPM_REG_U2_TMO);
    wire wr_req = REG_WR_I && (REG_ADDR_I == `HDPM_REG_LINK_REQ);
    wire [1:0] req = wr_req ? REG_WDATA_I[1:0] : `HDPM_REQ_NONE;
    wire in_u0 = (st_q == `HDPM_LS_U0);

    // ------------------------------------------------------------------------
    // partner request answer
    // ------------------------------------------------------------------------
    // accept only in u0 with the matching timeout enabled and nothing queued
    wire acc_u1 = PARTNER_U1_REQ_I && in_u0 && u1_on && !TX_PENDING_I;
    wire acc_u2 = PARTNER_U2_REQ_I && in_u0 && u2_on && !TX_PENDING_I;
    assign PARTNER_ACCEPT_O = acc_u1 || acc_u2;
    // a zero timeout rejects that state; both zero rejects everything
    assign PARTNER_REJECT_O = (PARTNER_U1_REQ_I || PARTNER_U2_REQ_I) && !PARTNER_ACCEPT_O;

    // packets routed to a suspended port vanish, the header is still acked
    assign PKT_DROP_O = ROUTED_PKT_I && (st_q == `HDPM_LS_U3);
    assign HDR_ACK_O  = ROUTED_PKT_I;
    assign PORT_STATE_O = st_q;

    // ------------------------------------------------------------------------
    // timer expiry, gated by enable and the no-initiate code
    // ------------------------------------------------------------------------
    wire u1_exp = u1_on && (u1_tmo_q != `HDPM_TMO_NO_INIT) && (u1_tmr_q >= u1_tmo_q);
    wire u2_exp = u2_on && (u2_tmo_q != `HDPM_TMO_NO_INIT) && (u2_tmr_q >= u2_tmo_q);
    // both zero: timers disabled and ignored
    wire tmr_run = u1_on || u2_on;

    // ------------------------------------------------------------------------
    // port power state machine
    // ------------------------------------------------------------------------
    always @* begin
        st_d = st_q;
        sw_try_d = sw_try_q;
        tmr_clr = 1'b0;
        u2_tmr_clr = 1'b0;
        if (req == `HDPM_REQ_U0) begin
            st_d = `HDPM_LS_U0;
            sw_try_d = 1'b0;
            tmr_clr = 1'b1;
        end else begin
            case (st_q)
                `HDPM_LS_U0: begin
                    if (ENTER_U3_I) begin
                        st_d = `HDPM_LS_U3;
                    end else if (req == `HDPM_REQ_U1) begin
                        st_d = `HDPM_LS_TRY_U1;
                        sw_try_d = 1'b1;
                    end else if (req == `HDPM_REQ_U2) begin
                        st_d = `HDPM_LS_TRY_U2;
                        sw_try_d = 1'b1;
                    end else if (acc_u1 || (u1_exp && !TX_PENDING_I)) begin
                        st_d = `HDPM_LS_TRY_U1;
                        sw_try_d = 1'b0;
                    end else if (acc_u2 || (u2_exp && !u1_on && !TX_PENDING_I)) begin
                        st_d = `HDPM_LS_TRY_U2;
                        sw_try_d = 1'b0;
                    end
                end
                `HDPM_LS_TRY_U1: begin
                    if (PARTNER_ACCEPT_I) begin
                        st_d = `HDPM_LS_U1;
                        u2_tmr_clr = 1'b1;
                    end else if (PARTNER_REJECT_I && !sw_try_q) begin
                        st_d = `HDPM_LS_U0;
                        tmr_clr = 1'b1;
                    end
                end
                `HDPM_LS_TRY_U2: begin
                    if (PARTNER_ACCEPT_I) begin
                        st_d = `HDPM_LS_U2;
                    end else if (PARTNER_REJECT_I && !sw_try_q) begin
                        st_d = `HDPM_LS_U0;
                        tmr_clr = 1'b1;
                    end
                end
                `HDPM_LS_U1: begin
                    if (PARTNER_EXIT_I || ROUTED_PKT_I) begin
                        st_d = `HDPM_LS_U0;
                        tmr_clr = 1'b1;
                    end else if (u2_exp) begin
                        st_d = `HDPM_LS_U2;
                    end
                end
                `HDPM_LS_U2: begin
                    if (PARTNER_EXIT_I || ROUTED_PKT_I) begin
                        st_d = `HDPM_LS_U0;
                        tmr_clr = 1'b1;
                    end
                end
                `HDPM_LS_U3: begin
                    if ((US_WAKE_I && u3_wake_seen_q) ||
                        (PARTNER_WAKE_I && US_STATE_I != `HDPM_LS_U3)) begin
                        st_d = `HDPM_LS_U0;
                        tmr_clr = 1'b1;
                    end
                end
                default: begin
                    st_d = `HDPM_LS_U0;
                end
            endcase
        end
        if (wr_u1 || wr_u2 || PKT_ACTIVITY_I) begin
            tmr_clr = 1'b1;
        end
    end

    // state, software retry flag and wake memory while suspended
    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            st_q <= `HDPM_LS_U0;
            sw_try_q <= 1'b0;
            u3_wake_seen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sw_try_q <= sw_try_d;
            // remember partner wake in u3 until the port leaves u3
            if (st_q != `HDPM_LS_U3) begin
                u3_wake_seen_q <= 1'b0;
            end else if (PARTNER_WAKE_I) begin
                u3_wake_seen_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // inactivity timers: u1 in 1 us ticks, u2 in 256 us ticks
    // ------------------------------------------------------------------------
    // tick prescalers restart on clear so the error is only ever positive
    wire u1_tick = (u1_div_q == U1_TICK_CYC[15:0] - 16'h0001);
    wire u2_tick = (u2_div_q == U2_TICK_CYC[15:0] - 16'h0001);
    wire u1_cnt_ok = in_u0 && tmr_run;
    wire u2_cnt_ok = (in_u0 || st_q == `HDPM_LS_U1) && tmr_run;

    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            u1_tmr_q <= `HDPM_TMO_ZERO;
            u2_tmr_q <= `HDPM_TMO_ZERO;
            u1_div_q <= 16'h0000;
            u2_div_q <= 16'h0000;
        end else begin
            if (tmr_clr || !u1_cnt_ok) begin
                u1_tmr_q <= `HDPM_TMO_ZERO;
                u1_div_q <= 16'h0000;
            end else begin
                u1_div_q <= u1_tick ? 16'h0000 : u1_div_q + 16'h0001;
                if (u1_tick && u1_tmr_q != `HDPM_TMO_NO_INIT) begin
                    u1_tmr_q <= u1_tmr_q + 8'h01;
                end
            end
            if (tmr_clr || u2_tmr_clr || !u2_cnt_ok) begin
                u2_tmr_q <= `HDPM_TMO_ZERO;
                u2_div_q <= 16'h0000;
            end else begin
                u2_div_q <= u2_tick ? 16'h0000 : u2_div_q + 16'h0001;
                if (u2_tick && u2_tmr_q != `HDPM_TMO_NO_INIT) begin
                    u2_tmr_q <= u2_tmr_q + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // link commands and upstream propagation
    // ------------------------------------------------------------------------
    // u2 exit with upstream in u1 waits the extra exit latency difference
    wire ent_u1 = (st_q != `HDPM_LS_U1) && (st_d == `HDPM_LS_U1);
    wire ent_u2 = (st_q != `HDPM_LS_U2) && (st_d == `HDPM_LS_U2);
    wire ent_u3 = (st_q != `HDPM_LS_U3) && (st_d == `HDPM_LS_U3);
    wire ex_u1 = (st_q == `HDPM_LS_U1) && (st_d == `HDPM_LS_U0);
    wire ex_u2 = (st_q == `HDPM_LS_U2) && (st_d == `HDPM_LS_U0);
    wire us_u0 = (US_STATE_I == `HDPM_LS_U0);

    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            ENTRY_U1_O <= 1'b0;
            ENTRY_U2_O <= 1'b0;
            EXIT_U0_O <= 1'b0;
            US_GO_U1_O <= 1'b0;
            US_GO_U2_O <= 1'b0;
            US_GO_U0_O <= 1'b0;
            wake_pend_q <= 1'b0;
            wake_dly_q <= 16'h0000;
        end else begin
            ENTRY_U1_O <= (st_d == `HDPM_LS_TRY_U1);
            ENTRY_U2_O <= (st_d == `HDPM_LS_TRY_U2) || ((st_q == `HDPM_LS_U1) && ent_u2);
            EXIT_U0_O <= ex_u1 || ex_u2;
            // pick one upstream command; u2 preferred where allowed
            US_GO_U1_O <= (ent_u1 && OTHERS_LE_U1_I && cfg_q[0]) ||
                          ((ent_u2 || ent_u3) && OTHERS_U2_U3_I && !cfg_q[1] && cfg_q[0]) ||
                          (ent_u2 && !OTHERS_LE_U2_I && OTHERS_LE_U1_I && cfg_q[0]);
            US_GO_U2_O <= (ent_u2 || ent_u3) && OTHERS_U2_U3_I && cfg_q[1];
            US_GO_U0_O <= ((ex_u1 || (ex_u2 && US_STATE_I == `HDPM_LS_U2)) && !us_u0) ||
                          (wake_pend_q && wake_dly_q == 16'h0000);
            if (ex_u2 && US_STATE_I == `HDPM_LS_U1) begin
                wake_pend_q <= 1'b1;
                wake_dly_q <= EXTRA_WAKE_CYC[15:0];
            end else if (wake_pend_q) begin
                if (wake_dly_q == 16'h0000) begin
                    wake_pend_q <= 1'b0;
                end else begin
                    wake_dly_q <= wake_dly_q - 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // register port: write side and registered read data
    // ------------------------------------------------------------------------
    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            u1_tmo_q <= `HDPM_TMO_ZERO;
            u2_tmo_q <= `HDPM_TMO_ZERO;
            cfg_q <= 2'b00;
            REG_RDATA_O <= 8'h00;
        end else begin
            if (wr_u1) begin
                u1_tmo_q <= REG_WDATA_I;
            end
            if (wr_u2) begin
                u2_tmo_q <= REG_WDATA_I;
            end
            if (REG_WR_I && REG_ADDR_I == `HDPM_REG_CFG) begin
                cfg_q <= REG_WDATA_I[1:0];
            end
            if (REG_RD_I) begin
                case (REG_ADDR_I)
                    `HDPM_REG_U1_TMO:   REG_RDATA_O <= u1_tmo_q;
                    `HDPM_REG_U2_TMO:   REG_RDATA_O <= u2_tmo_q;
                    `HDPM_REG_STATUS:   REG_RDATA_O <= {4'h0, sw_try_q, st_q};
                    `HDPM_REG_U1_TIMER: REG_RDATA_O <= u1_tmr_q;
                    `HDPM_REG_U2_TIMER: REG_RDATA_O <= u2_tmr_q;
                    `HDPM_REG_CFG:      REG_RDATA_O <= {6'h00, cfg_q};
                    default:            REG_RDATA_O <= 8'h00;
                endcase
            end else begin
                REG_RDATA_O <= 8'h00;
            end
        end
    end

endmodule

// *** hdpm_defines.vh ***
// constants for the hub downstream port link power manager
`ifndef HDPM_DEFINES_VH
`define HDPM_DEFINES_VH
// ----------------------------------------------------------------------------
// register map (word offsets on the plain register port)
// ----------------------------------------------------------------------------
`define HDPM_REG_U1_TMO      4'h0
`define HDPM_REG_U2_TMO      4'h1
`define HDPM_REG_LINK_REQ    4'h2
`define HDPM_REG_STATUS      4'h3
`define HDPM_REG_U1_TIMER    4'h4
`define HDPM_REG_U2_TIMER    4'h5
`define HDPM_REG_CFG         4'h6
// ----------------------------------------------------------------------------
// field values
// ----------------------------------------------------------------------------
`define HDPM_TMO_ZERO        8'h00
`define HDPM_TMO_NO_INIT     8'hFF
`define HDPM_REQ_NONE        2'h0
`define HDPM_REQ_U0          2'h1
`define HDPM_REQ_U1          2'h2
`define HDPM_REQ_U2          2'h3
// link state encoding for the port and upstream link
`define HDPM_LS_U0           3'h0
`define HDPM_LS_U1           3'h1
`define HDPM_LS_U2           3'h2
`define HDPM_LS_U3           3'h3
`define HDPM_LS_TRY_U1       3'h4
`define HDPM_LS_TRY_U2       3'h5
// ----------------------------------------------------------------------------
// timing: u1 timer counts in 1 us ticks, u2 timer in 256 us ticks
// ----------------------------------------------------------------------------
`define HDPM_CLK_MHZ         100
`define HDPM_U1_TICK_NS      1000
`define HDPM_U2_TICK_US      256
`define HDPM_CLK_NS          10
`define HDPM_U1_TICK_CYC     (`HDPM_U1_TICK_NS / `HDPM_CLK_NS)
`define HDPM_U2_TICK_CYC     (`HDPM_U2_TICK_US * `HDPM_CLK_MHZ)
`endif

// *** hdpm_link_monitor.sv ***
// assertion checker for the downstream port link power manager
`include "hdpm_defines.vh"
module hdpm_link_monitor (
    input wire       REF_CLK_I,
    input wire       RST_N_I,
    input wire [3:0] REG_ADDR_I,
    input wire [7:0] REG_WDATA_I,
    input wire       REG_WR_I,
    input wire       PARTNER_U1_REQ_I,
    input wire       PARTNER_U2_REQ_I,
    input wire       PARTNER_EXIT_I,
    input wire       PARTNER_ACCEPT_I,
    input wire       TX_PENDING_I,
    input wire       ROUTED_PKT_I,
    input wire [2:0] US_STATE_I,
    input wire       OTHERS_LE_U1_I,
    input wire       PARTNER_ACCEPT_O,
    input wire       PARTNER_REJECT_O,
    input wire       ENTRY_U1_O,
    input wire       EXIT_U0_O,
    input wire       PKT_DROP_O,
    input wire       HDR_ACK_O,
    input wire       US_GO_U1_O,
    input wire       US_GO_U0_O,
    input wire [2:0] PORT_STATE_O
);
    reg [7:0] u1_tmo_q;
    reg [7:0] u2_tmo_q;
    reg       us_u1_en_q;
    wire      in_u0 = PORT_STATE_O == `HDPM_LS_U0;
    // ------------------------------------------------------------------
    // shadow settings
    // ------------------------------------------------------------------
    // copied from the write strobe, so no read traffic is needed here
    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            u1_tmo_q   <= 8'h00;
            u2_tmo_q   <= 8'h00;
            us_u1_en_q <= 1'b0;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == `HDPM_REG_U1_TMO) u1_tmo_q <= REG_WDATA_I;
            if (REG_ADDR_I == `HDPM_REG_U2_TMO) u2_tmo_q <= REG_WDATA_I;
            if (REG_ADDR_I == `HDPM_REG_CFG) us_u1_en_q <= REG_WDATA_I[0];
        end
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking mon_cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    a_zero_tmo_reject: assert property (
        (PARTNER_U1_REQ_I && u1_tmo_q == 8'h00) || (PARTNER_U2_REQ_I && u2_tmo_q == 8'h00)
        |-> PARTNER_REJECT_O && !PARTNER_ACCEPT_O) else $error("zero timeout request taken");
    a_pending_reject: assert property (
        (PARTNER_U1_REQ_I || PARTNER_U2_REQ_I) && TX_PENDING_I |-> !PARTNER_ACCEPT_O)
        else $error("request accepted with traffic pending");
    a_u1_accept: assert property (
        in_u0 && PARTNER_U1_REQ_I && !PARTNER_U2_REQ_I && u1_tmo_q != 8'h00 && !TX_PENDING_I
        |-> PARTNER_ACCEPT_O) else $error("u1 request not accepted");
    a_u2_accept: assert property (
        in_u0 && PARTNER_U2_REQ_I && !PARTNER_U1_REQ_I && u2_tmo_q != 8'h00 && !TX_PENDING_I
        |-> PARTNER_ACCEPT_O) else $error("u2 request not accepted");
    a_try_on_accept: assert property (
        in_u0 && PARTNER_ACCEPT_O && PARTNER_U1_REQ_I
        |=> PORT_STATE_O == `HDPM_LS_TRY_U1 && ENTRY_U1_O) else $error("no u1 attempt");
    a_enter_u1: assert property (
        PORT_STATE_O == `HDPM_LS_TRY_U1 && PARTNER_ACCEPT_I |=> PORT_STATE_O == `HDPM_LS_U1)
        else $error("u1 not entered after partner accept");
    a_exit_to_u0: assert property (
        PORT_STATE_O inside {`HDPM_LS_U1, `HDPM_LS_U2} && PARTNER_EXIT_I
        |=> in_u0 ##[0:1] EXIT_U0_O) else $error("partner exit not followed");
    a_u3_drop: assert property (
        ROUTED_PKT_I |-> HDR_ACK_O && PKT_DROP_O == (PORT_STATE_O == `HDPM_LS_U3))
        else $error("routed packet handling wrong");
    a_us_go_u1: assert property (
        PORT_STATE_O == `HDPM_LS_U1 && $past(PORT_STATE_O) == `HDPM_LS_TRY_U1
        && OTHERS_LE_U1_I && us_u1_en_q && US_STATE_I == `HDPM_LS_U0
        |-> ##[0:2] US_GO_U1_O) else $error("upstream u1 not started");
    a_us_wake_u1: assert property (
        $past(PORT_STATE_O) == `HDPM_LS_U1 && in_u0
        && US_STATE_I inside {`HDPM_LS_U1, `HDPM_LS_U2} |-> ##[0:2] US_GO_U0_O)
        else $error("upstream not woken from u1 exit");
    a_us_stay_u0: assert property (
        US_STATE_I == `HDPM_LS_U0 |-> !US_GO_U0_O) else $error("wake sent to upstream in u0");
endmodule

bind hdpm_dsport_link_pm hdpm_link_monitor hdpm_link_monitor_i (.*);

// *** hdpm_link_partner.sv ***
// behavioural downstream link partner answering entry attempts
module hdpm_link_partner (
    input  wire clk_i,
    input  wire entry_i,
    output reg  accept_o,
    output reg  reject_o
);
    timeunit 1ns;
    timeprecision 1ns;
    reg     nak_q = 1'b0; // set by the bench to refuse every attempt
    integer cnt   = 0;
    // answer four cycles into an attempt; a held attempt is answered again
    always @(posedge clk_i) begin
        accept_o <= 1'b0;
        reject_o <= 1'b0;
        cnt      <= entry_i ? cnt + 1 : 0;
        if (entry_i && cnt == 3) begin
            accept_o <= !nak_q;
            reject_o <= nak_q;
            cnt      <= 0;
        end
    end
endmodule

// *** tb.sv ***
// self-checking bench for the downstream port link power manager
`include "hdpm_defines.vh"
`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin err_count++; \
    $display("BAD %s exp %0h got %0h", n, e, v); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    reg       REF_CLK_I = 1'b0, RST_N_I = 1'b0, REG_WR_I = 1'b0, REG_RD_I = 1'b0;
    reg [3:0] REG_ADDR_I = 4'h0;
    reg [7:0] REG_WDATA_I = 8'h00;
    reg       PARTNER_U1_REQ_I = 1'b0, PARTNER_U2_REQ_I = 1'b0, PARTNER_EXIT_I = 1'b0;
    reg       PARTNER_WAKE_I = 1'b0, TX_PENDING_I = 1'b0, PKT_ACTIVITY_I = 1'b0;
    reg       ROUTED_PKT_I = 1'b0, ENTER_U3_I = 1'b0, US_WAKE_I = 1'b0, OTHERS_LE_U1_I = 1'b0;
    reg       OTHERS_LE_U2_I = 1'b0, OTHERS_U2_U3_I = 1'b0;
    reg [2:0] US_STATE_I = 3'h0;
    wire      PARTNER_ACCEPT_I, PARTNER_REJECT_I, PARTNER_ACCEPT_O, PARTNER_REJECT_O;
    wire      ENTRY_U1_O, ENTRY_U2_O, EXIT_U0_O, PKT_DROP_O, HDR_ACK_O;
    wire      US_GO_U1_O, US_GO_U2_O, US_GO_U0_O;
    wire [7:0] REG_RDATA_O;
    wire [2:0] PORT_STATE_O;
    integer   err_count = 0, total_checks = 0, g1_cnt = 0, n;
    // short tick parameters keep the timer scenarios to a few cycles
    hdpm_dsport_link_pm #(.U1_TICK_CYC(4), .U2_TICK_CYC(8), .EXTRA_WAKE_CYC(16'h0010))
        hdpm_dsport_link_pm_i (.*);
    hdpm_link_partner hdpm_link_partner_i (.clk_i(REF_CLK_I), .entry_i(ENTRY_U1_O | ENTRY_U2_O),
        .accept_o(PARTNER_ACCEPT_I), .reject_o(PARTNER_REJECT_I));
    // clock and upstream u1 pulse counter
    always #5 REF_CLK_I = ~REF_CLK_I;
    always @(posedge REF_CLK_I) if (US_GO_U1_O === 1'b1) g1_cnt <= g1_cnt + 1;
    // ------------------------------------------------------------------
    // bus and wait helpers
    // ------------------------------------------------------------------
    task wr8(input [3:0] a, input [7:0] d);
        @(posedge REF_CLK_I);
        REG_ADDR_I  <= a;
        REG_WDATA_I <= d;
        REG_WR_I    <= 1'b1;
        @(posedge REF_CLK_I) REG_WR_I <= 1'b0;
    endtask
    task rd8(input [3:0] a, input [7:0] e);
        @(posedge REF_CLK_I);
        REG_ADDR_I <= a;
        REG_RD_I   <= 1'b1;
        @(posedge REF_CLK_I) REG_RD_I <= 1'b0;
        #1 `CHK("rdata", e, REG_RDATA_O)
    endtask
    // bounded wait for a port state, n returns the cycles spent
    task wait_st(input [2:0] s);
        n = 0;
        while (PORT_STATE_O !== s && n < 300) begin
            @(posedge REF_CLK_I);
            #1 n++;
        end
    endtask
    // one-cycle partner request; the answer is combinational, seen mid-cycle
    task ask(input two, input acc);
        @(posedge REF_CLK_I) {PARTNER_U2_REQ_I, PARTNER_U1_REQ_I} <= two ? 2'b10 : 2'b01;
        #5 `CHK("accept", acc, PARTNER_ACCEPT_O)
        `CHK("reject", !acc, PARTNER_REJECT_O)
        @(posedge REF_CLK_I) {PARTNER_U2_REQ_I, PARTNER_U1_REQ_I} <= 2'b00;
    endtask
    task pexit;
        @(posedge REF_CLK_I) PARTNER_EXIT_I <= 1'b1;
        @(posedge REF_CLK_I) PARTNER_EXIT_I <= 1'b0;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_idle;
        rd8(`HDPM_REG_STATUS, 8'h00);
        rd8(4'h7, 8'h00);
        ask(1'b0, 1'b0);
        ask(1'b1, 1'b0);
    endtask
    task t_u1_ff;
        wr8(`HDPM_REG_U1_TMO, `HDPM_TMO_NO_INIT);
        ask(1'b1, 1'b0);
        ask(1'b0, 1'b1);
        wait_st(`HDPM_LS_U1);
        `CHK("state", `HDPM_LS_U1, PORT_STATE_O)
        pexit;
        repeat (40) @(posedge REF_CLK_I);
        #1 `CHK("state", `HDPM_LS_U0, PORT_STATE_O)
    endtask
    task t_pend;
        TX_PENDING_I <= 1'b1;
        ask(1'b0, 1'b0);
        wr8(`HDPM_REG_U1_TMO, 8'h01);
        repeat (30) @(posedge REF_CLK_I);
        #1 `CHK("state", `HDPM_LS_U0, PORT_STATE_O)
        // disarm the expired timer first, or the next scenario starts mid-entry
        wr8(`HDPM_REG_U1_TMO, 8'h00);
        TX_PENDING_I <= 1'b0;
    endtask
    task t_timer;
        wr8(`HDPM_REG_CFG, 8'h01);
        OTHERS_LE_U1_I <= 1'b1;
        wr8(`HDPM_REG_U1_TMO, 8'h03);
        wait_st(`HDPM_LS_TRY_U1);
        `CHK("u1 wait", 1'b1, n >= 12 && n <= 17)
        wait_st(`HDPM_LS_U1);
        repeat (3) @(posedge REF_CLK_I);
        `CHK("up u1", 1, g1_cnt)
        US_STATE_I <= `HDPM_LS_U1;
        pexit;
        wr8(`HDPM_REG_U2_TMO, 8'h02);
        wait_st(`HDPM_LS_U1);
        wait_st(`HDPM_LS_U2);
        `CHK("u2 wait", 1'b1, n >= 16 && n <= 20)
        pexit;
        for (n = 0; n < 40 && US_GO_U0_O !== 1'b1; n++) @(posedge REF_CLK_I) #1;
        `CHK("wake lat", 1'b1, n >= 17 && n <= 19)
    endtask
    task t_retry;
        wr8(`HDPM_REG_U1_TMO, 8'h00);
        wr8(`HDPM_REG_U2_TMO, 8'h00);
        wr8(`HDPM_REG_LINK_REQ, {6'h00, `HDPM_REQ_U0});
        hdpm_link_partner_i.nak_q = 1'b1;
        wr8(`HDPM_REG_LINK_REQ, {6'h00, `HDPM_REQ_U1});
        repeat (20) @(posedge REF_CLK_I);
        #1 `CHK("state", `HDPM_LS_TRY_U1, PORT_STATE_O)
        `CHK("entry", 1'b1, ENTRY_U1_O)
        wr8(`HDPM_REG_LINK_REQ, {6'h00, `HDPM_REQ_U0});
        wait_st(`HDPM_LS_U0);
        `CHK("u0 lat", 1'b1, n <= 2)
        wr8(`HDPM_REG_U1_TMO, 8'h03);
        wait_st(`HDPM_LS_TRY_U1);
        wait_st(`HDPM_LS_U0);
        `CHK("back lat", 1'b1, n <= 6)
        hdpm_link_partner_i.nak_q = 1'b0;
        wr8(`HDPM_REG_U1_TMO, 8'h00);
    endtask
    task t_u3;
        wr8(`HDPM_REG_CFG, 8'h03);
        OTHERS_U2_U3_I <= 1'b1;
        @(posedge REF_CLK_I) ENTER_U3_I <= 1'b1;
        @(posedge REF_CLK_I) ENTER_U3_I <= 1'b0;
        #1 `CHK("up u2", 1'b1, US_GO_U2_O)
        wait_st(`HDPM_LS_U3);
        @(posedge REF_CLK_I) ROUTED_PKT_I <= 1'b1;
        #1 `CHK("drop", 1'b1, PKT_DROP_O)
        `CHK("ack", 1'b1, HDR_ACK_O)
        US_STATE_I <= `HDPM_LS_U3;
        @(posedge REF_CLK_I) {ROUTED_PKT_I, PARTNER_WAKE_I} <= 2'b01;
        @(posedge REF_CLK_I) {PARTNER_WAKE_I, US_WAKE_I} <= 2'b01;
        @(posedge REF_CLK_I) US_WAKE_I <= 1'b0;
        wait_st(`HDPM_LS_U0);
        `CHK("u3 wake", 1'b1, n <= 4)
        wr8(`HDPM_REG_U1_TMO, 8'h40);
        repeat (20) @(posedge REF_CLK_I);
        @(posedge REF_CLK_I) PKT_ACTIVITY_I <= 1'b1;
        @(posedge REF_CLK_I) PKT_ACTIVITY_I <= 1'b0;
        rd8(`HDPM_REG_U1_TIMER, 8'h00);
    endtask
    // ------------------------------------------------------------------
    // verdict, main sequence and watchdog
    // ------------------------------------------------------------------
    task final_report;
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge REF_CLK_I);
        RST_N_I <= 1'b1;
        t_idle;
        t_u1_ff;
        t_pend;
        t_timer;
        t_retry;
        t_u3;
        final_report;
    end
    // a hang costs at most five thousand cycles
    initial begin
        #50000;
        err_count++;
        final_report;
    end
endmodule
